/* File: logic/ssic_pkg.sv */
package ssic_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] SSIC_OFS_MODE = 4'h0;
    localparam logic [3:0] SSIC_OFS_CTRL = 4'h4;

    // ------------------------------------------------------------------
    // input mode field positions
    // ------------------------------------------------------------------
    localparam int SSIC_MODE_SLICE_HI  = 7;
    localparam int SSIC_MODE_SLICE_LO  = 6;
    localparam int SSIC_MODE_CMPSEL    = 5;
    localparam int SSIC_MODE_POLARITY  = 4;
    localparam int SSIC_MODE_VSRC      = 3;
    localparam int SSIC_MODE_LOWPASS   = 2;
    localparam int SSIC_MODE_RSVD      = 1;
    localparam int SSIC_MODE_RATIO     = 0;

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int SSIC_CTRL_IRQ_EN    = 7;
    localparam int SSIC_CTRL_IRQ_FLAG  = 6;
    localparam int SSIC_CTRL_VCK_SEL   = 5;
    localparam int SSIC_CTRL_VCMP_EN   = 4;
    localparam int SSIC_CTRL_CSCK_SEL  = 3;
    localparam int SSIC_CTRL_HLK_FORCE = 2;
    localparam int SSIC_CTRL_HLK_VBLK  = 1;
    localparam int SSIC_CTRL_FIELD     = 0;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] SSIC_MODE_RST = 8'h00;
    localparam logic [7:0] SSIC_CTRL_RST = 8'h00;
    localparam logic [7:0] SSIC_MODE_WMASK = 8'hFD;
    localparam logic [1:0] SSIC_SLICE_10IRE = 2'h0;
    localparam logic [1:0] SSIC_SLICE_05IRE = 2'h1;
    localparam logic [1:0] SSIC_SLICE_15IRE = 2'h2;
    localparam logic [1:0] SSIC_SLICE_20IRE = 2'h3;
    localparam logic [9:0] SSIC_RATIO_576 = 10'd576;
    localparam logic [9:0] SSIC_RATIO_448 = 10'd448;

    typedef enum logic [1:0] {
        SSIC_LVL_10,
        SSIC_LVL_5,
        SSIC_LVL_15,
        SSIC_LVL_20
    } ssic_slice_t;

    // steering outputs to the analog/digital separator
    typedef struct packed {
        ssic_slice_t slice_level;
        logic        use_schmitt;
        logic        sync_polarity;
        logic        vsrc_csync;
        logic        lowpass_on;
        logic [9:0]  ref_ratio;
        logic        vck_complement;
        logic        vcmp_enable;
        logic        csync_ref_clock;
        logic        half_line_killer;
    } ssic_steer_t;

    // separator events into the block
    typedef struct packed {
        logic ext_vertical_pulse;
        logic field_window;
        logic csync;
        logic separated_hpulse;
        logic fc_hpulse;
        logic comp_hpulse;
        logic complement_insert;
        logic vblank;
    } ssic_event_t;

endpackage : ssic_pkg

/* File: logic/ssic_top.sv */
`timescale 1ns/1ns
`default_nettype none

module ssic_top
    import ssic_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // power state
    input  wire logic        low_power_i,
    // separator events and combined sync pin
    input  wire ssic_event_t evt_i,
    input  wire logic        csync_pin_i,
    output logic             csync_pin_o,
    output logic             csync_pin_oe_o,
    // steering and derived signals
    output ssic_steer_t      steer_o,
    output logic             hsource_o,
    output logic             vsource_o,
    output logic             vcount_in_o,
    output logic             vcount_clk_o,
    output logic             ext_vertical_irq_o
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [3:0] adr,
                                 input logic [3:0] ofs);
        hit = (adr[3:2] == ofs[3:2]);
    endfunction : hit

    logic req;
    logic wr;
    logic rd;
    logic sel_mode;
    logic sel_ctrl;
    logic mapped;

    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign sel_mode = hit(wb_adr_i, SSIC_OFS_MODE);
    assign sel_ctrl = hit(wb_adr_i, SSIC_OFS_CTRL);
    assign mapped   = sel_mode | sel_ctrl;
    assign wr       = req & mapped & wb_we_i & wb_sel_i[0];
    assign rd       = req & mapped & ~wb_we_i;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  mode_ff;
    logic [7:0]  nxt_mode;
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic        flag_seen_ff;
    logic        nxt_flag_seen;
    logic        vpulse_ff;
    logic        nxt_vpulse;
    logic [1:0]  ins_cnt_ff;
    logic [1:0]  nxt_ins_cnt;
    logic        ack_ff;
    logic        nxt_ack;
    logic        err_ff;
    logic        nxt_err;
    logic [31:0] rdat_ff;
    logic [31:0] nxt_rdat;
    logic        vrise;
    logic        hlk_force;

    assign vrise = evt_i.ext_vertical_pulse & ~vpulse_ff;
    assign hlk_force = (ctrl_ff[SSIC_CTRL_HLK_FORCE]
                        & (ins_cnt_ff == 2'd3))
                     | (ctrl_ff[SSIC_CTRL_HLK_VBLK] & evt_i.vblank);

    always_comb begin
        nxt_mode      = mode_ff;
        nxt_ctrl      = ctrl_ff;
        nxt_flag_seen = flag_seen_ff;
        nxt_vpulse    = evt_i.ext_vertical_pulse;
        nxt_ins_cnt   = ins_cnt_ff;
        nxt_ack       = 1'b0;
        nxt_err       = 1'b0;
        nxt_rdat      = rdat_ff;
        if (req) begin
            nxt_ack = mapped;
            nxt_err = ~mapped;
        end
        // successive complement insert counter, reset by a real pulse
        if (evt_i.separated_hpulse) begin
            nxt_ins_cnt = 2'd0;
        end else if (evt_i.complement_insert && ins_cnt_ff != 2'd3) begin
            nxt_ins_cnt = ins_cnt_ff + 2'd1;
        end
        if (rd) begin
            nxt_rdat = {24'h00_0000, sel_mode ? mode_ff : ctrl_ff};
            if (sel_ctrl && ctrl_ff[SSIC_CTRL_IRQ_FLAG]) begin
                nxt_flag_seen = 1'b1;
            end
        end
        if (wr && sel_mode) begin
            nxt_mode = wb_dat_i[7:0] & SSIC_MODE_WMASK;
        end
        if (wr && sel_ctrl) begin
            nxt_ctrl[7:1] = wb_dat_i[7:1];
            // flag only clears after it was read as one; one is ignored
            nxt_ctrl[SSIC_CTRL_IRQ_FLAG] = ctrl_ff[SSIC_CTRL_IRQ_FLAG]
                & ~(flag_seen_ff & ~wb_dat_i[SSIC_CTRL_IRQ_FLAG]);
            if (flag_seen_ff && !wb_dat_i[SSIC_CTRL_IRQ_FLAG]) begin
                nxt_flag_seen = 1'b0;
            end
        end
        if (vrise) begin
            nxt_ctrl[SSIC_CTRL_IRQ_FLAG] = 1'b1;
            nxt_ctrl[SSIC_CTRL_FIELD]    = evt_i.field_window;
        end
        if (low_power_i) begin
            nxt_mode = SSIC_MODE_RST
                     | (mode_ff & (8'h01 << SSIC_MODE_CMPSEL));
            nxt_ctrl      = SSIC_CTRL_RST;
            nxt_flag_seen = 1'b0;
            nxt_ins_cnt   = 2'd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff      <= SSIC_MODE_RST;
            ctrl_ff      <= SSIC_CTRL_RST;
            flag_seen_ff <= 1'b0;
            vpulse_ff    <= 1'b0;
            ins_cnt_ff   <= 2'd0;
            ack_ff       <= 1'b0;
            err_ff       <= 1'b0;
            rdat_ff      <= 32'h0000_0000;
        end else begin
            mode_ff      <= nxt_mode;
            ctrl_ff      <= nxt_ctrl;
            flag_seen_ff <= nxt_flag_seen;
            vpulse_ff    <= nxt_vpulse;
            ins_cnt_ff   <= nxt_ins_cnt;
            ack_ff       <= nxt_ack;
            err_ff       <= nxt_err;
            rdat_ff      <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdat_ff;

    // ------------------------------------------------------------------
    // steering
    // ------------------------------------------------------------------
    logic pin_out;

    always_comb begin
        steer_o.slice_level =
            ssic_slice_t'(mode_ff[SSIC_MODE_SLICE_HI:SSIC_MODE_SLICE_LO]);
        steer_o.use_schmitt     = mode_ff[SSIC_MODE_CMPSEL];
        steer_o.sync_polarity   = mode_ff[SSIC_MODE_POLARITY];
        steer_o.vsrc_csync      = mode_ff[SSIC_MODE_VSRC];
        steer_o.lowpass_on      = mode_ff[SSIC_MODE_LOWPASS];
        steer_o.ref_ratio       = mode_ff[SSIC_MODE_RATIO]
                                ? SSIC_RATIO_448 : SSIC_RATIO_576;
        steer_o.vck_complement  = ctrl_ff[SSIC_CTRL_VCK_SEL];
        steer_o.vcmp_enable     = ctrl_ff[SSIC_CTRL_VCMP_EN];
        steer_o.csync_ref_clock = ctrl_ff[SSIC_CTRL_CSCK_SEL];
        steer_o.half_line_killer = hlk_force;
    end

    // polarity flips the pin input; comparator path drives the pin
    assign pin_out   = evt_i.csync;
    assign hsource_o = mode_ff[SSIC_MODE_CMPSEL]
                     ? (csync_pin_i ^ mode_ff[SSIC_MODE_POLARITY])
                     : evt_i.csync;
    assign vsource_o = mode_ff[SSIC_MODE_VSRC] ? hsource_o
                     : evt_i.ext_vertical_pulse;
    assign vcount_in_o = mode_ff[SSIC_MODE_LOWPASS]
                       ? (vsource_o | evt_i.separated_hpulse)
                       : vsource_o;
    assign vcount_clk_o = ctrl_ff[SSIC_CTRL_VCK_SEL]
                        ? evt_i.comp_hpulse : evt_i.fc_hpulse;

    assign csync_pin_o    = pin_out;
    assign csync_pin_oe_o = ~rst_i & ~low_power_i
                          & ~mode_ff[SSIC_MODE_CMPSEL];

    assign ext_vertical_irq_o = ctrl_ff[SSIC_CTRL_IRQ_EN]
                              & ctrl_ff[SSIC_CTRL_IRQ_FLAG];

endmodule : ssic_top

`default_nettype wire

/* File: verif/ssic_props.sv */
`timescale 1ns/1ns
`default_nettype none
module ssic_props
    import ssic_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // power and pin
    input wire logic        low_power_i,
    input wire ssic_event_t evt_i,
    input wire logic        csync_pin_i,
    input wire logic        csync_pin_o,
    input wire logic        csync_pin_oe_o,
    // steering
    input wire ssic_steer_t steer_o,
    input wire logic        hsource_o,
    input wire logic        vsource_o,
    input wire logic        vcount_in_o,
    input wire logic        vcount_clk_o,
    input wire logic        ext_vertical_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_lp; low_power_i ##1 low_power_i; endsequence
    property p_oe_off; disable iff (1'b0)
        rst_i || low_power_i |-> !csync_pin_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven");
    property p_oe_dir;
        !low_power_i |-> csync_pin_oe_o == !steer_o.use_schmitt; endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("pin dir");
    property p_hsrc; hsource_o == (steer_o.use_schmitt ?
        csync_pin_i ^ steer_o.sync_polarity : evt_i.csync); endproperty
    a_hsrc: assert property (p_hsrc) else $error("h source");
    property p_vsrc; vsource_o == (steer_o.vsrc_csync ?
        hsource_o : evt_i.ext_vertical_pulse); endproperty
    a_vsrc: assert property (p_vsrc) else $error("v source");
    property p_vcnt; vcount_in_o == (vsource_o ||
        (steer_o.lowpass_on && evt_i.separated_hpulse)); endproperty
    a_vcnt: assert property (p_vcnt) else $error("v count in");
    property p_vclk; vcount_clk_o == (steer_o.vck_complement ?
        evt_i.comp_hpulse : evt_i.fc_hpulse); endproperty
    a_vclk: assert property (p_vclk) else $error("v clock");
    property p_lp_mode; s_lp |-> !steer_o.lowpass_on && !steer_o.vsrc_csync
        && steer_o.ref_ratio == SSIC_RATIO_576
        && steer_o.slice_level == SSIC_LVL_10; endproperty
    a_lp_mode: assert property (p_lp_mode) else $error("mode kept");
    property p_lp_ctrl; s_lp |-> !ext_vertical_irq_o && !steer_o.vcmp_enable
        && !steer_o.vck_complement && !steer_o.csync_ref_clock; endproperty
    a_lp_ctrl: assert property (p_lp_ctrl) else $error("ctrl kept");
    property p_keep; s_lp |-> $stable(steer_o.use_schmitt); endproperty
    a_keep: assert property (p_keep) else $error("select lost");
    property p_rst; disable iff (1'b0) rst_i |=> !ext_vertical_irq_o
        && steer_o.slice_level == SSIC_LVL_10; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_pin_out; csync_pin_oe_o |-> csync_pin_o == evt_i.csync;
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("pin data");
    property p_lp_hlk; s_lp |-> !steer_o.half_line_killer; endproperty
    a_lp_hlk: assert property (p_lp_hlk) else $error("killer kept");
endmodule : ssic_props
bind ssic_top ssic_props i_props (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .low_power_i        (low_power_i),
    .evt_i              (evt_i),
    .csync_pin_i        (csync_pin_i),
    .csync_pin_o        (csync_pin_o),
    .csync_pin_oe_o     (csync_pin_oe_o),
    .steer_o            (steer_o),
    .hsource_o          (hsource_o),
    .vsource_o          (vsource_o),
    .vcount_in_o        (vcount_in_o),
    .vcount_clk_o       (vcount_clk_o),
    .ext_vertical_irq_o (ext_vertical_irq_o)
);
`default_nettype wire

/* File: verif/ssic_src.sv */
`timescale 1ns/1ns
`default_nettype none
module ssic_src
    import ssic_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // commanded levels and pulses
    input  wire ssic_event_t lvl_i,
    input  wire ssic_event_t pls_i,
    // toward the block
    output ssic_event_t      evt_o,
    output logic             pin_o
);
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    // free-running sync from the video source
    always_comb nxt_cnt = cnt_ff + 3'h1;
    always_ff @(posedge clk_i) cnt_ff <= rst_i ? 3'h0 : nxt_cnt;
    always_comb begin
        evt_o = lvl_i | pls_i;
        evt_o.csync = cnt_ff[2];
    end
    // external sync on the pin, seen only while the block listens
    assign pin_o = ~cnt_ff[1];
endmodule : ssic_src
`default_nettype wire

/* File: verif/tb_ssic_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_ssic_top
    import ssic_pkg::*;
;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lp = 0, e;
    logic [3:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [7:0] q, d;
    wire logic [31:0] rdat;
    wire logic ack, err, pin_o, oe, irq, hs, vs, vi, vc, src_pin;
    wire ssic_steer_t st;
    wire ssic_event_t evt;
    ssic_event_t lvl = '0, pls = '0;
    int fail_count = 0, check_count = 0, cyc_n = 0;
    ssic_slice_t sl[4] = '{SSIC_LVL_10, SSIC_LVL_5, SSIC_LVL_15, SSIC_LVL_20};
    ssic_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .low_power_i(lp), .evt_i(evt), .csync_pin_i(oe ? pin_o : src_pin),
        .csync_pin_o(pin_o), .csync_pin_oe_o(oe), .steer_o(st),
        .hsource_o(hs), .vsource_o(vs), .vcount_in_o(vi),
        .vcount_clk_o(vc), .ext_vertical_irq_o(irq));
    ssic_src i_src (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl),
        .pls_i(pls), .evt_o(evt), .pin_o(src_pin));
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task chk(input logic [9:0] s, input logic [9:0] x);
        check_count++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, s, x);
        end
    endtask : chk
    task wb(input logic w, input logic [3:0] a, input logic [7:0] dd);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, dd};
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = rdat[7:0];
        e = err;
        cyc <= 0;
        stb <= 0;
    endtask : wb
    task rd(input logic [3:0] a, input logic [7:0] x);
        wb(0, a, 8'h00);
        chk(q, x);
    endtask : rd
    task pulse(input logic [7:0] m, input logic [7:0] l);
        @(posedge clk_i);
        {pls, lvl} <= {m, l};
        @(posedge clk_i);
        pls <= '0;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask : pulse
    function logic [9:0] ratio(input logic b);
        return b ? 10'd448 : 10'd576;
    endfunction : ratio
    initial begin
        void'($urandom(83958));
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        rd(SSIC_OFS_MODE, 8'h00);
        rd(SSIC_OFS_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wb(1, SSIC_OFS_MODE, {i[1:0], 6'h00});
            @(negedge clk_i);
            chk(st.slice_level, sl[i]);
        end
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 8'hFF : 8'($urandom);
            if (!d[5]) d[4] = 1'b0;
            wb(1, SSIC_OFS_MODE, d);
            @(negedge clk_i);
            chk(st.use_schmitt, d[5]);
            chk(st.sync_polarity, d[4]);
            chk(oe, !d[5]);
            chk(st.vsrc_csync, d[3]);
            chk(st.lowpass_on, d[2]);
            chk(st.ref_ratio, ratio(d[0]));
            rd(SSIC_OFS_MODE, d & 8'hFD);
        end
        wb(1, SSIC_OFS_MODE, 8'hFF);
        wb(1, SSIC_OFS_CTRL, 8'hBE);
        @(posedge clk_i) lp <= 1;
        repeat (3) @(posedge clk_i);
        lp <= 0;
        rd(SSIC_OFS_MODE, 8'h20);
        rd(SSIC_OFS_CTRL, 8'h00);
        wb(1, SSIC_OFS_MODE, 8'h00);
        @(posedge clk_i) lp <= 1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(oe, 0);
        @(posedge clk_i) lp <= 0;
        wb(1, SSIC_OFS_MODE, 8'h20);
        rd(SSIC_OFS_MODE, 8'h20);
        // chip reset in mid-run: pin released, select bit cleared
        @(posedge clk_i) rst_i <= 1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(oe, 0);
        @(posedge clk_i) rst_i <= 0;
        rd(SSIC_OFS_MODE, 8'h00);
        wb(1, SSIC_OFS_CTRL, 8'h80);
        pulse(8'h80, 8'h40);
        chk(irq, 1);
        wb(1, SSIC_OFS_CTRL, 8'h80);
        rd(SSIC_OFS_CTRL, 8'hC1);
        wb(1, SSIC_OFS_CTRL, 8'h00);
        rd(SSIC_OFS_CTRL, 8'h01);
        pulse(8'h80, 8'h00);
        chk(irq, 0);
        rd(SSIC_OFS_CTRL, 8'h40);
        wb(1, SSIC_OFS_CTRL, 8'h41);
        rd(SSIC_OFS_CTRL, 8'h40);
        wb(1, SSIC_OFS_CTRL, 8'h04);
        repeat (2) pulse(8'h02, 8'h00);
        chk(st.half_line_killer, 0);
        pulse(8'h02, 8'h00);
        chk(st.half_line_killer, 1);
        pulse(8'h10, 8'h00);
        chk(st.half_line_killer, 0);
        wb(1, SSIC_OFS_CTRL, 8'h02);
        pulse(8'h00, 8'h01);
        chk(st.half_line_killer, 1);
        wb(1, SSIC_OFS_CTRL, 8'h38);
        @(negedge clk_i);
        chk({st.vck_complement, st.vcmp_enable}, 3);
        chk(st.half_line_killer, 0);
        chk(st.csync_ref_clock, 1);
        wb(0, 4'h8, 8'h00);
        chk(e, 1);
        test_done();
    end
endmodule : tb_ssic_top
`default_nettype wire
